//--- hw/led_dimming_fault_control.v
// Brightness source selection, current ramp and protection logic of an LED backlight driver.
//
// Operation
// R1: Mode 010 ramps over code times duty.
// R2: Mode 010 ramp spans product difference minus one.
// R3: Mode 011 drives duty times ramped code.
// R4: Mode 011 duty change acts immediately, code ramps.
// R5: Mode 100 scales mapped current by duty.
// R6: Modes 011/100 ramp spans code difference minus one.
// R7: Over limit turns switch off until next cycle.
// R8: Flash forces the fixed 3A limit.
// R9: Count intervals where every cycle hit limit.
// R10: Over-current flag when count exceeds two per window.
// R11: Over-voltage stops switching and sets its flag.
// R12: Threshold select 00/01/10/11 gives 17/23/30/38V.
// R13: Pin below 40mV means open string.
// R14: Open sets both flags; mode 01 disables string.
// R15: Short needs pin high for 2ms continuously.
// R16: Short mode 00 disables short detection.
// R17: Short mode 01 flags but keeps strings.
// R18: Short mode 10 flags and disables shorted strings.
// R19: Over-temperature shuts down until indication clears.
// R20: Any protection ends flash and clears its bit.
// R21: Source, ramp settings change only while disabled.
// R22: Ramp one code per step time.
// R23: Clear interval counter at each window end.
// R24: Fault flags stay until reset.
`timescale 1ns/1ps
`include "led_dim_consts.vh"
module led_dimming_fault_control #(
  parameter CODE_W = 11,
  parameter RAMP_UNIT_PS = `RAMP_UNIT_PS,
  parameter OCP_INTERVAL_CYC = `OCP_INTERVAL_CYC,
  parameter SHORT_HOLD_CYC = `SHORT_HOLD_CYC
) (
  input wire mclk, // 100 MHz clock.
  input wire nrst, // Power-on reset, active low.
  input wire [9:0] paddr, // APB byte address.
  input wire psel, // APB select.
  input wire penable, // APB access phase.
  input wire pwrite, // APB write.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata, // APB read data.
  output reg pready, // APB ready.
  output reg pslverr, // APB error for unmapped address.
  input wire [CODE_W-1:0] pwmDuty, // Sampled PWM duty, full scale 2048.
  input wire cycleStart, // Pulse at each switching cycle start.
  input wire [3:0] switchCurrent, // Switch current, 0.25 A units.
  input wire [5:0] outputVolts, // Output voltage in volts.
  input wire [2:0] ledPinLow, // Channel pin below 40mV.
  input wire [2:0] ledPinHigh, // Channel pin above short threshold.
  input wire overTemp, // Die over-temperature indication.
  output reg lowSideSwitch, // Low-side switch gate.
  output reg [CODE_W-1:0] ledCode, // Code to the current mapper.
  output reg [CODE_W-1:0] currentScale, // Duty applied after mapping.
  output reg [2:0] stringEnable, // Per-string sink enable.
  output reg [1:0] shortThresholdSel // Short comparator threshold.
);

  // ----------
  // Registers and derived settings
  // ----------
  localparam [11:0] FULL_DUTY = 12'h800;
  wire rampBusy;
  reg [7:0] enable_q, brightCtrl_q, limits_q, protect_q;
  reg [2:0] brightLo_q, brightLoStage_q;
  reg [7:0] brightHi_q;
  reg flashEnable_q;
  reg overcurrentFaultFlag_q, overvoltageFaultFlag_q, openStringFaultFlag_q;
  reg shortStringFaultFlag_q, thermalFaultFlag_q;
  reg [2:0] stringOff_q;
  reg softReset_q;
  wire [7:0] index = paddr[9:2];
  wire access = psel && penable && pready;
  wire wrEn = access && pwrite;
  wire chipOn = enable_q[0];
  wire [2:0] chanOn = enable_q[3:1];
  wire [2:0] brightnessSourceSel = brightCtrl_q[`SRC_LSB+2:`SRC_LSB];
  wire rampEnable = brightCtrl_q[`RAMP_EN_BIT];
  wire [2:0] rampStepTimeSel = brightCtrl_q[2:0];
  wire [1:0] currentLimitSel = limits_q[1:0];
  wire [1:0] overvoltageThresholdSel = limits_q[`OVP_SEL_LSB+1:`OVP_SEL_LSB];
  wire [1:0] shortResponseSel = protect_q[`SHORT_MODE_LSB+1:`SHORT_MODE_LSB];
  wire [1:0] openResponseSel = protect_q[`OPEN_MODE_LSB+1:`OPEN_MODE_LSB];
  wire [CODE_W-1:0] brightCode = {brightHi_q, brightLo_q};
  wire settingsOpen = !chipOn || (chanOn == 3'h0);
  wire mapped = (index == `IDX_SOFT_RESET) || (index == `IDX_ENABLE) || (index == `IDX_BRIGHT_CTRL) ||
                (index == `IDX_LIMITS) || (index == `IDX_FLASH) || (index == `IDX_BRIGHT_LO) ||
                (index == `IDX_BRIGHT_HI) || (index == `IDX_PROTECT) || (index == `IDX_FAULTS) ||
                (index == `IDX_STATUS);

  // Step time doubles with each select code from the base unit.
  wire [39:0] stepPs = RAMP_UNIT_PS << rampStepTimeSel;
  wire [39:0] stepCyc = (stepPs + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;

  // ----------
  // Protection events shared by the flash clear and the flags
  // ----------
  reg [5:0] ovpLevel;
  reg [3:0] limitLevel;
  wire overVolt = outputVolts > ovpLevel; // R11
  wire [2:0] liveStrings = chanOn & ~stringOff_q & {3{chipOn}};
  wire [2:0] openHit = ledPinLow & liveStrings; // R13
  wire [2:0] shortHit;
  wire ocpEvent;
  wire protectEvent = overVolt || (openHit != 3'h0) || (shortHit != 3'h0) || ocpEvent || overTemp;

  // Threshold and current limit decode.
  always @*
  begin
    case (overvoltageThresholdSel) // R12
      2'h0: ovpLevel = `OVP_17V;
      2'h1: ovpLevel = `OVP_23V;
      2'h2: ovpLevel = `OVP_30V;
      default: ovpLevel = `OVP_38V;
    endcase
    if (flashEnable_q)
      limitLevel = `LIMIT_FLASH_3A; // R8
    else
    begin
      case (currentLimitSel)
        2'h0: limitLevel = `LIMIT_0A75;
        2'h1: limitLevel = `LIMIT_1A00;
        2'h2: limitLevel = `LIMIT_1A25;
        default: limitLevel = `LIMIT_1A50;
      endcase
    end
  end

  // ----------
  // APB slave: one wait state, read data latched at the wait-state edge, write at the completing edge
  // ----------
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready)
      begin
        case (index)
          `IDX_ENABLE: prdata <= {24'h0, enable_q};
          `IDX_BRIGHT_CTRL: prdata <= {24'h0, brightCtrl_q};
          `IDX_LIMITS: prdata <= {24'h0, limits_q};
          `IDX_FLASH: prdata <= {31'h0, flashEnable_q};
          `IDX_BRIGHT_LO: prdata <= {29'h0, brightLoStage_q};
          `IDX_BRIGHT_HI: prdata <= {24'h0, brightHi_q};
          `IDX_PROTECT: prdata <= {24'h0, protect_q};
          `IDX_FAULTS: prdata <= {27'h0, openStringFaultFlag_q, shortStringFaultFlag_q, thermalFaultFlag_q,
                                  overcurrentFaultFlag_q, overvoltageFaultFlag_q};
          `IDX_STATUS: prdata <= {25'h0, rampBusy, lowSideSwitch, overTemp, stringOff_q, overVolt};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // Configuration registers; a soft reset returns every one of them to default.
  // The low code bits are staged and only take effect with the high byte,
  // so an 11-bit change never shows a half-written code.
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      softReset_q <= 1'b0;
      enable_q <= `RST_ENABLE;
      brightCtrl_q <= `RST_BRIGHT_CTRL;
      limits_q <= `RST_LIMITS;
      protect_q <= `RST_PROTECT;
      brightLo_q <= 3'h0;
      brightLoStage_q <= 3'h0;
      brightHi_q <= 8'h0;
      flashEnable_q <= 1'b0;
    end
    else if (softReset_q)
    begin
      softReset_q <= 1'b0;
      enable_q <= `RST_ENABLE;
      brightCtrl_q <= `RST_BRIGHT_CTRL;
      limits_q <= `RST_LIMITS;
      protect_q <= `RST_PROTECT;
      brightLo_q <= 3'h0;
      brightLoStage_q <= 3'h0;
      brightHi_q <= 8'h0;
      flashEnable_q <= 1'b0;
    end
    else
    begin
      softReset_q <= wrEn && (index == `IDX_SOFT_RESET) && pwdata[0];
      if (wrEn && (index == `IDX_ENABLE))
        enable_q <= {4'h0, pwdata[3:0]};
      if (wrEn && (index == `IDX_BRIGHT_CTRL) && settingsOpen) // R21
        brightCtrl_q <= pwdata[7:0];
      if (wrEn && (index == `IDX_LIMITS))
        limits_q <= pwdata[7:0];
      if (wrEn && (index == `IDX_PROTECT))
        protect_q <= pwdata[7:0];
      if (wrEn && (index == `IDX_BRIGHT_LO))
        brightLoStage_q <= pwdata[2:0];
      if (wrEn && (index == `IDX_BRIGHT_HI))
      begin
        brightHi_q <= pwdata[7:0];
        brightLo_q <= brightLoStage_q;
      end
      if (protectEvent)
        flashEnable_q <= 1'b0; // R20
      else if (wrEn && (index == `IDX_FLASH))
        flashEnable_q <= pwdata[0];
    end
  end

  // ----------
  // Brightness source and ramp
  // ----------
  wire [2*CODE_W-1:0] codeTimesDuty = brightCode * pwmDuty;
  wire [CODE_W-1:0] productCode = codeTimesDuty[2*CODE_W-1:CODE_W];
  reg [CODE_W-1:0] rampTarget;
  wire [CODE_W-1:0] rampCode;
  wire [2*CODE_W-1:0] rampTimesDuty = rampCode * pwmDuty;
  wire [CODE_W-1:0] rampTarget0 = (chipOn && (chanOn != 3'h0)) ? rampTarget : {CODE_W{1'b0}};

  // What the ramp steps through depends on the source mode.
  always @*
  begin
    case (brightnessSourceSel)
      `SRC_DUTY_ONLY: rampTarget = pwmDuty;
      `SRC_PRODUCT_RAMP: rampTarget = productCode; // R1 R2
      `SRC_RAMP_THEN_PRODUCT: rampTarget = brightCode; // R3 R6
      `SRC_CURRENT_SCALED: rampTarget = brightCode; // R5 R6
      default: rampTarget = brightCode;
    endcase
  end

  led_step_ramp #(
    .CODE_W(CODE_W),
    .CNT_W(20)
  ) ramp (
    .mclk(mclk),
    .nrst(nrst),
    .clear(softReset_q),
    .rampOn(rampEnable),
    .stepCycles(stepCyc[19:0]),
    .target(rampTarget0),
    .code_q(rampCode),
    .busy(rampBusy)
  );

  // Mode 011 multiplies after the ramp, so a duty change lands in one cycle.
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ledCode <= {CODE_W{1'b0}};
      currentScale <= {CODE_W{1'b0}};
    end
    else
    begin
      if (brightnessSourceSel == `SRC_RAMP_THEN_PRODUCT)
        ledCode <= rampTimesDuty[2*CODE_W-1:CODE_W]; // R3 R4
      else
        ledCode <= rampCode;
      if (brightnessSourceSel == `SRC_CURRENT_SCALED)
        currentScale <= pwmDuty; // R5
      else
        currentScale <= FULL_DUTY[CODE_W-1:0] - 1'b1;
    end
  end

  // ----------
  // Switch control and over-current counting
  // ----------
  reg hitThisCycle_q, allHit_q, sawCycle_q;
  reg [19:0] intervalCnt_q;
  reg [2:0] windowCnt_q;
  reg [3:0] ocpCount_q;
  wire overLimit = switchCurrent > limitLevel;
  wire intervalEnd = (intervalCnt_q == OCP_INTERVAL_CYC - 1);
  wire intervalAllHit = allHit_q && sawCycle_q && !(cycleStart && !hitThisCycle_q);
  assign ocpEvent = intervalEnd && (windowCnt_q == `OCP_WINDOW_INTERVALS - 1) &&
                    (ocpCount_q + intervalAllHit > `OCP_COUNT_LIMIT);
  wire runAllowed = chipOn && !overVolt && !overTemp; // R11 R19

  // Gate on at each cycle start, off for the rest of a cycle once over limit.
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      lowSideSwitch <= 1'b0;
    else if (!runAllowed || softReset_q)
      lowSideSwitch <= 1'b0;
    else if (cycleStart)
      lowSideSwitch <= 1'b1; // R7
    else if (overLimit)
      lowSideSwitch <= 1'b0; // R7
  end

  // An interval counts only if every cycle in it reached the limit.
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      hitThisCycle_q <= 1'b0;
      allHit_q <= 1'b1;
      sawCycle_q <= 1'b0;
      intervalCnt_q <= 20'h0;
      windowCnt_q <= 3'h0;
      ocpCount_q <= 4'h0;
    end
    else if (softReset_q)
    begin
      hitThisCycle_q <= 1'b0;
      allHit_q <= 1'b1;
      sawCycle_q <= 1'b0;
      intervalCnt_q <= 20'h0;
      windowCnt_q <= 3'h0;
      ocpCount_q <= 4'h0;
    end
    else
    begin
      if (cycleStart)
        hitThisCycle_q <= overLimit;
      else if (overLimit)
        hitThisCycle_q <= 1'b1;
      if (intervalEnd)
      begin
        intervalCnt_q <= 20'h0;
        allHit_q <= 1'b1;
        sawCycle_q <= 1'b0;
        windowCnt_q <= windowCnt_q + 1'b1;
        if (windowCnt_q == `OCP_WINDOW_INTERVALS - 1)
          ocpCount_q <= 4'h0; // R23
        else
          ocpCount_q <= ocpCount_q + intervalAllHit; // R9
      end
      else
      begin
        intervalCnt_q <= intervalCnt_q + 1'b1;
        if (cycleStart && sawCycle_q && !hitThisCycle_q)
          allHit_q <= 1'b0;
        if (cycleStart)
          sawCycle_q <= 1'b1;
      end
    end
  end

  // ----------
  // Short detection per string
  // ----------
  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1)
    begin : shortDet
      reg [21:0] holdCnt_q;
      // Any drop below the threshold restarts the 2ms count.
      always @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
          holdCnt_q <= 22'h0;
        else if (softReset_q || !ledPinHigh[s] || !liveStrings[s] || (shortResponseSel == `SHORT_OFF)) // R16
          holdCnt_q <= 22'h0;
        else if (holdCnt_q != SHORT_HOLD_CYC)
          holdCnt_q <= holdCnt_q + 1'b1; // R15
      end
      assign shortHit[s] = (holdCnt_q == SHORT_HOLD_CYC);
    end
  endgenerate

  // ----------
  // Fault flags and string marking
  // ----------
  // Flags only set; nothing but a reset clears them, so a fault that has
  // passed stays visible to software.
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      overcurrentFaultFlag_q <= 1'b0;
      overvoltageFaultFlag_q <= 1'b0;
      openStringFaultFlag_q <= 1'b0;
      shortStringFaultFlag_q <= 1'b0;
      thermalFaultFlag_q <= 1'b0;
      stringOff_q <= 3'h0;
      stringEnable <= 3'h0;
      shortThresholdSel <= 2'h0;
    end
    else if (softReset_q)
    begin
      overcurrentFaultFlag_q <= 1'b0;
      overvoltageFaultFlag_q <= 1'b0;
      openStringFaultFlag_q <= 1'b0;
      shortStringFaultFlag_q <= 1'b0;
      thermalFaultFlag_q <= 1'b0;
      stringOff_q <= 3'h0;
      stringEnable <= 3'h0;
      shortThresholdSel <= 2'h0;
    end
    else
    begin
      if (ocpEvent)
        overcurrentFaultFlag_q <= 1'b1; // R10 R24
      if (overVolt || (openHit != 3'h0))
        overvoltageFaultFlag_q <= 1'b1; // R11 R14 R24
      if (openHit != 3'h0)
        openStringFaultFlag_q <= 1'b1; // R14
      if (shortHit != 3'h0)
        shortStringFaultFlag_q <= 1'b1; // R17 R18
      if (overTemp)
        thermalFaultFlag_q <= 1'b1;
      stringOff_q <= stringOff_q |
                     (openHit & {3{openResponseSel == `OPEN_MARK_OFF}}) | // R14
                     (shortHit & {3{shortResponseSel == `SHORT_MARK_OFF}}); // R18
      stringEnable <= liveStrings & {3{!overTemp}}; // R19
      shortThresholdSel <= protect_q[`SHORT_TH_LSB+1:`SHORT_TH_LSB];
    end
  end

endmodule

//--- hw/led_dim_consts.vh
// Offsets, field positions, reset values and timing figures of the dimming and fault controller.
`ifndef LED_DIM_CONSTS_VH
`define LED_DIM_CONSTS_VH

// ----------
// Register indices (byte address is four times the index)
// ----------
`define IDX_SOFT_RESET 8'h01
`define IDX_ENABLE 8'h10
`define IDX_BRIGHT_CTRL 8'h11
`define IDX_LIMITS 8'h13
`define IDX_FLASH 8'h17
`define IDX_BRIGHT_LO 8'h18
`define IDX_BRIGHT_HI 8'h19
`define IDX_PROTECT 8'h1e
`define IDX_FAULTS 8'h1f
`define IDX_STATUS 8'h20

// ----------
// Reset values
// ----------
`define RST_ENABLE 8'h0e
`define RST_BRIGHT_CTRL 8'h30
`define RST_LIMITS 8'h0c
`define RST_PROTECT 8'h00

// ----------
// Field positions and codes
// ----------
`define SRC_LSB 4
`define RAMP_EN_BIT 3
`define OVP_SEL_LSB 2
`define SHORT_TH_LSB 6
`define SHORT_MODE_LSB 4
`define OPEN_MODE_LSB 2
`define SRC_DUTY_ONLY 3'h1
`define SRC_PRODUCT_RAMP 3'h2
`define SRC_RAMP_THEN_PRODUCT 3'h3
`define SRC_CURRENT_SCALED 3'h4
`define SHORT_OFF 2'h0
`define SHORT_FLAG 2'h1
`define SHORT_MARK_OFF 2'h2
`define OPEN_MARK_OFF 2'h1

// ----------
// Limits in units of 0.25 A, thresholds in volts
// ----------
`define LIMIT_0A75 4'h3
`define LIMIT_1A00 4'h4
`define LIMIT_1A25 4'h5
`define LIMIT_1A50 4'h6
`define LIMIT_FLASH_3A 4'hc
`define OVP_17V 6'h11
`define OVP_23V 6'h17
`define OVP_30V 6'h1e
`define OVP_38V 6'h26

// ----------
// Timing
// ----------
`define CLK_PERIOD_PS 10000
`define RAMP_UNIT_PS 7812500
`define OCP_INTERVAL_NS 128000
`define OCP_WINDOW_INTERVALS 8
`define OCP_COUNT_LIMIT 2
`define SHORT_HOLD_NS 2000000
`define OCP_INTERVAL_CYC ((`OCP_INTERVAL_NS * 1000) / `CLK_PERIOD_PS)
`define SHORT_HOLD_CYC ((`SHORT_HOLD_NS * 1000) / `CLK_PERIOD_PS)

`endif

//--- hw/led_step_ramp.v
// Step-wise brightness ramp: one code per step time toward a target code.
`timescale 1ns/1ps
module led_step_ramp #(
  parameter CODE_W = 11,
  parameter CNT_W = 20
) (
  input wire mclk, // System clock.
  input wire nrst, // Asynchronous reset, active low.
  input wire clear, // Synchronous software reset.
  input wire rampOn, // Ramp enabled; otherwise the code follows at once.
  input wire [CNT_W-1:0] stepCycles, // Clock cycles between two steps.
  input wire [CODE_W-1:0] target, // Code to move toward.
  output reg [CODE_W-1:0] code_q, // Present code.
  output wire busy // Code has not reached the target.
);

  reg [CNT_W-1:0] wait_q;

  assign busy = (code_q != target);

  // ----------
  // Stepping
  // ----------
  // The first step goes at once and each later step waits a full step time,
  // so a move of N codes lasts (N - 1) step times.
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      code_q <= {CODE_W{1'b0}};
      wait_q <= {CNT_W{1'b0}};
    end
    else if (clear)
    begin
      code_q <= {CODE_W{1'b0}};
      wait_q <= {CNT_W{1'b0}};
    end
    else if (!rampOn)
    begin
      code_q <= target;
      wait_q <= {CNT_W{1'b0}};
    end
    else if (wait_q != {CNT_W{1'b0}})
      wait_q <= wait_q - 1'b1;
    else if (busy)
    begin
      if (target > code_q) // R22
        code_q <= code_q + 1'b1;
      else
        code_q <= code_q - 1'b1;
      wait_q <= stepCycles - 1'b1;
    end
  end

endmodule

//--- bench/led_host_model.sv
// Host model: APB master that configures the controller.
`timescale 1ns/1ps
module led_host_model (
  input wire mclk, // Clock.
  output logic [9:0] paddr, // Byte address.
  output logic psel, // Select.
  output logic penable, // Access phase.
  output logic pwrite, // Direction.
  output logic [31:0] pwdata, // Write data.
  input wire [31:0] prdata, // Read data.
  input wire pready, // Ready.
  input wire pslverr, // Error.
  output logic hung // Set when a transfer got no answer.
);
  // Idle bus at time zero.
  initial
  begin
    {paddr, psel, penable, pwrite, pwdata, hung} = '0;
  end

  // One transfer; all is taken at the edge where ready is sampled high.
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    begin
      n = 0;
      @(posedge mclk);
      paddr <= {i, 2'b00};
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20)
      begin
        n++;
        @(posedge mclk);
      end
      hung = (n == 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule

//--- bench/led_dimming_fault_control_properties.sv
// Port-level assertions for the dimming and fault controller.
`timescale 1ns/1ps
module led_dim_checker (
  input wire mclk, // Clock.
  input wire nrst, // Reset, active low.
  input wire psel, // Select.
  input wire penable, // Access phase.
  input wire pwrite, // Write.
  input wire pready, // Ready.
  input wire pslverr, // Error.
  input wire cycleStart, // Cycle start.
  input wire [3:0] switchCurrent, // Switch current.
  input wire [5:0] outputVolts, // Output voltage.
  input wire overTemp, // Over-temperature.
  input wire lowSideSwitch, // Switch gate.
  input wire [1:0] shortThresholdSel // Short threshold.
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Above every selectable threshold or limit the switch opens.
  AST_OVP_STOP: assert property (outputVolts > 6'h26 |=> !lowSideSwitch)
    else $error("switch on above threshold");
  AST_OTP_STOP: assert property (overTemp |=> !lowSideSwitch)
    else $error("switch on while hot");
  AST_LIMIT_OFF: assert property (switchCurrent > 4'hc && !cycleStart |=> !lowSideSwitch)
    else $error("switch on above limit");
  AST_OFF_HOLD: assert property (!lowSideSwitch && !cycleStart |=> !lowSideSwitch)
    else $error("switch on without cycle start");
  AST_APB_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  AST_STH_CHANGE: assert property ($changed(shortThresholdSel) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2) || $past(pready && pwrite, 3))
    else $error("threshold moved without write");

  // Main scenarios.
  COV_ERR: cover property (pslverr);
  COV_ON: cover property ($rose(lowSideSwitch));
  COV_HOT: cover property (overTemp ##1 !lowSideSwitch);
endmodule

bind led_dimming_fault_control led_dim_checker i_led_dim_checker (.mclk(mclk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .cycleStart(cycleStart),
  .switchCurrent(switchCurrent), .outputVolts(outputVolts), .overTemp(overTemp),
  .lowSideSwitch(lowSideSwitch), .shortThresholdSel(shortThresholdSel));

//--- bench/led_dimming_fault_control_tb_top.sv
// Self-checking bench for the dimming and fault controller.
`timescale 1ns/1ps
`include "led_dim_consts.vh"
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      n_fail++; \
      $display("wrong value at %0t: %0h, want %0h", $time, (a), (e)); \
    end \
  end
module led_dimming_fault_control_tb_top;
  logic mclk, nrst, cycleStart, overTemp, er, pwrite, psel, penable, pready, pslverr, lowSideSwitch;
  logic [10:0] pwmDuty;
  logic [3:0] switchCurrent;
  logic [5:0] outputVolts;
  logic [2:0] ledPinLow, ledPinHigh, stringEnable;
  logic [31:0] rd, pwdata, prdata;
  logic [9:0] paddr;
  logic [10:0] ledCode, currentScale;
  logic [1:0] shortThresholdSel;
  logic [5:0] thr [4] = '{`OVP_17V, `OVP_23V, `OVP_30V, `OVP_38V};
  int n_fail = 0;
  int check_count = 0;

  // Short counts keep the run brief: 4-cycle ramp step, 20-cycle short hold.
  led_dimming_fault_control #(.RAMP_UNIT_PS(40000), .OCP_INTERVAL_CYC(16), .SHORT_HOLD_CYC(20))
    i_led_dimming_fault_control (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwmDuty(pwmDuty), .cycleStart(cycleStart), .switchCurrent(switchCurrent), .outputVolts(outputVolts),
    .ledPinLow(ledPinLow), .ledPinHigh(ledPinHigh), .overTemp(overTemp), .lowSideSwitch(lowSideSwitch),
    .ledCode(ledCode), .currentScale(currentScale), .stringEnable(stringEnable),
    .shortThresholdSel(shortThresholdSel));
  led_host_model i_led_host_model (.mclk(mclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung());

  // Clock.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    begin
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // A transfer with no answer ends the run.
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    begin
      i_led_host_model.xfer(w, i, d, rd, er);
      if (i_led_host_model.hung === 1'b1)
      begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask

  task automatic wait_n(input int n);
    begin
      repeat (n) @(posedge mclk);
      @(negedge mclk);
    end
  endtask

  task automatic pulse();
    begin
      @(posedge mclk);
      cycleStart <= 1'b1;
      @(posedge mclk);
      cycleStart <= 1'b0;
      wait_n(1);
    end
  endtask

  // Locked settings are written with the chip off.
  task automatic cfg(input logic [7:0] ctl, input logic [10:0] code);
    begin
      bus(1'b1, `IDX_ENABLE, 32'h0);
      bus(1'b1, `IDX_BRIGHT_CTRL, 32'(ctl));
      bus(1'b1, `IDX_BRIGHT_LO, 32'(code[2:0]));
      bus(1'b1, `IDX_BRIGHT_HI, 32'(code[10:3]));
      bus(1'b1, `IDX_ENABLE, 32'h0f);
      wait_n(4);
    end
  endtask

  task automatic t_regs();
    begin
      bus(1'b0, `IDX_ENABLE, 32'h0);
      `CHK(rd, 32'(`RST_ENABLE))
      bus(1'b0, `IDX_BRIGHT_CTRL, 32'h0);
      `CHK(rd, 32'(`RST_BRIGHT_CTRL))
      bus(1'b0, `IDX_LIMITS, 32'h0);
      `CHK(rd, 32'(`RST_LIMITS))
      bus(1'b0, 8'h02, 32'h0);
      `CHK(er, 1'b1)
      $display("t_regs done");
    end
  endtask

  task automatic t_modes();
    begin
      pwmDuty <= 11'h400;
      cfg(8'h20, 11'h400);
      `CHK(ledCode, 11'h200)
      cfg(8'h30, 11'h400);
      `CHK(ledCode, 11'h200)
      @(posedge mclk);
      pwmDuty <= 11'h7ff;
      wait_n(1);
      `CHK(ledCode, 11'h3ff)
      `CHK(currentScale, 11'h7ff)
      @(posedge mclk);
      pwmDuty <= 11'h300;
      cfg(8'h40, 11'h400);
      `CHK(ledCode, 11'h400)
      `CHK(currentScale, 11'h300)
      cfg(8'h48, 11'h008);
      `CHK(ledCode > 0 && ledCode < 8, 1'b1)
      wait_n(40);
      `CHK(ledCode, 11'h008)
      $display("t_modes done");
    end
  endtask

  task automatic t_limit();
    begin
      for (int s = 0; s < 4; s++)
      begin
        bus(1'b1, `IDX_LIMITS, 32'(8'h0c + s));
        switchCurrent <= 4'(s + 3);
        pulse();
        `CHK(lowSideSwitch, 1'b1)
        @(posedge mclk);
        switchCurrent <= 4'(s + 4);
        wait_n(1);
        `CHK(lowSideSwitch, 1'b0)
        @(posedge mclk);
        switchCurrent <= 4'h0;
      end
      $display("t_limit done");
    end
  endtask

  task automatic t_ovp();
    begin
      for (int s = 0; s < 4; s++)
      begin
        bus(1'b1, `IDX_LIMITS, 32'(s * 4));
        outputVolts <= thr[s];
        pulse();
        `CHK(lowSideSwitch, 1'b1)
        @(posedge mclk);
        outputVolts <= thr[s] + 6'h1;
        wait_n(1);
        `CHK(lowSideSwitch, 1'b0)
        @(posedge mclk);
        outputVolts <= thr[s];
        pulse();
        `CHK(lowSideSwitch, 1'b1)
      end
      bus(1'b0, `IDX_FAULTS, 32'h0);
      `CHK(rd[0], 1'b1)
      $display("t_ovp done");
    end
  endtask

  task automatic t_otp();
    begin
      bus(1'b1, `IDX_FLASH, 32'h1);
      @(posedge mclk);
      overTemp <= 1'b1;
      wait_n(1);
      `CHK(lowSideSwitch, 1'b0)
      bus(1'b0, `IDX_FLASH, 32'h0);
      `CHK(rd[0], 1'b0)
      overTemp <= 1'b0;
      pulse();
      `CHK(lowSideSwitch, 1'b1)
      $display("t_otp done");
    end
  endtask

  task automatic t_open();
    begin
      bus(1'b1, `IDX_SOFT_RESET, 32'h1);
      bus(1'b1, `IDX_PROTECT, 32'h04);
      bus(1'b1, `IDX_ENABLE, 32'h0f);
      ledPinLow <= 3'b001;
      wait_n(3);
      `CHK(stringEnable, 3'b110)
      @(posedge mclk);
      ledPinLow <= 3'b000;
      bus(1'b0, `IDX_FAULTS, 32'h0);
      `CHK(rd[4], 1'b1)
      `CHK(rd[0], 1'b1)
      $display("t_open done");
    end
  endtask

  // A broken hold does not count; a full one acts per mode.
  task automatic t_short();
    begin
      for (int m = 0; m < 3; m++)
      begin
        bus(1'b1, `IDX_SOFT_RESET, 32'h1);
        bus(1'b1, `IDX_PROTECT, 32'(8'hc0 + m * 16));
        bus(1'b1, `IDX_ENABLE, 32'h0f);
        `CHK(shortThresholdSel, 2'b11)
        ledPinHigh <= 3'b010;
        repeat (12) @(posedge mclk);
        ledPinHigh <= 3'b000;
        @(posedge mclk);
        ledPinHigh <= 3'b010;
        repeat (12) @(posedge mclk);
        bus(1'b0, `IDX_FAULTS, 32'h0);
        `CHK(rd[3], 1'b0)
        repeat (30) @(posedge mclk);
        bus(1'b0, `IDX_FAULTS, 32'h0);
        `CHK(rd[3], m != 0)
        `CHK(stringEnable, (m == 2) ? 3'b101 : 3'b111)
        ledPinHigh <= 3'b000;
      end
      $display("t_short done");
    end
  endtask

  // Main sequence.
  initial
  begin
    {nrst, cycleStart, overTemp, switchCurrent, outputVolts, ledPinLow, ledPinHigh, pwmDuty} = '0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_modes();
    t_limit();
    t_ovp();
    t_otp();
    t_open();
    t_short();
    tally_and_finish();
  end
endmodule
